// >>> design/rate_converter_pkg.sv
// rate_converter_pkg: offsets, field layout, reset values and codes for the
// rate converter control registers.
// assumes: an 8-bit host register port with a 7-bit page-0 address.
`default_nettype none
package rate_converter_pkg;
  localparam logic [6:0] ctl1_addr = 7'h2D;
  localparam logic [6:0] ctl2_addr = 7'h2E;
  localparam logic [6:0] att_left_addr = 7'h30;
  localparam logic [6:0] att_right_addr = 7'h31;
  localparam logic [7:0] ctl_reset = 8'h00;
  // control 1 field layout
  localparam int src_lsb = 0;
  localparam int clk_lsb = 2;
  localparam int mute_bit = 4;
  localparam int track_bit = 6;
  localparam logic [7:0] ctl1_mask = 8'h5F;
  // control 2 field layout
  localparam int depth_lsb = 0;
  localparam int ddn_bit = 2;
  localparam int dem_lsb = 3;
  localparam int auto_bit = 5;
  localparam logic [7:0] ctl2_mask = 8'h3F;
  // prebuffer sample counts
  localparam logic [6:0] depth_64 = 7'h40;
  localparam logic [6:0] depth_32 = 7'h20;
  localparam logic [6:0] depth_16 = 7'h10;
  localparam logic [6:0] depth_8 = 7'h08;
  // consumer channel status emphasis field, 50/15 us
  localparam logic [2:0] cs_emph_5015 = 3'h1;
  // consumer channel status rate codes
  localparam logic [3:0] cs_fs_44k1 = 4'h0;
  localparam logic [3:0] cs_fs_48k = 4'h2;
  localparam logic [3:0] cs_fs_32k = 4'h3;
  typedef enum logic [1:0] {
    src_port_a = 2'h0,
    src_port_b = 2'h1,
    src_receiver = 2'h2,
    src_reserved = 2'h3
  } input_source_t;
  typedef enum logic [1:0] {
    ref_master = 2'h0,
    ref_rx_in = 2'h1,
    ref_rx_recovered = 2'h2,
    ref_reserved = 2'h3
  } refclk_source_t;
  typedef enum logic [1:0] {
    dem_off = 2'h0,
    dem_48k = 2'h1,
    dem_44k1 = 2'h2,
    dem_32k = 2'h3
  } deemph_t;
endpackage : rate_converter_pkg
`default_nettype wire

// >>> design/ctl_reg_if.sv
// ctl_reg_if: write strobe and data carried to one control register.
// assumes: a single clock domain.
`default_nettype none
interface ctl_reg_if;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] q;
  modport owner (output wr, output wdata, input q);
  modport store (input wr, input wdata, output q);
endinterface : ctl_reg_if
`default_nettype wire

// >>> design/ctl_reg8.sv
// ctl_reg8: one 8-bit control register with writable mask.
// assumes: synchronous active-low reset.
`default_nettype none
module ctl_reg8 #(
  parameter logic [7:0] mask = 8'hFF,
  parameter logic [7:0] reset_value = 8'h00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // access
  ctl_reg_if.store port
);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      port.q <= reset_value;
    end else if (port.wr) begin
      port.q <= port.wdata & mask;
    end
  end
endmodule : ctl_reg8
`default_nettype wire

// >>> design/rate_converter_control_regs.sv
// rate_converter_control_regs: two control registers steering the rate
// converter core, plus the output mute/attenuation stage.
// assumes: host port is synchronous to core_clk; attenuation values come in.
`default_nettype none
module rate_converter_control_regs #(
  parameter int sample_width = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // host register port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [6:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_hit,
  // attenuation settings from their own registers
  input wire logic [7:0] left_attenuation_value,
  input wire logic [7:0] right_attenuation_value,
  // receiver channel status
  input wire logic [2:0] rx_cs_emphasis,
  input wire logic [3:0] rx_cs_rate,
  // converter output stage
  input wire logic [sample_width-1:0] in_left,
  input wire logic [sample_width-1:0] in_right,
  output logic [sample_width-1:0] out_left,
  output logic [sample_width-1:0] out_right,
  // configuration to the core
  output rate_converter_pkg::input_source_t converter_input_select,
  output rate_converter_pkg::refclk_source_t converter_refclk_select,
  output logic [6:0] prebuffer_depth,
  output logic downsample_mode,
  output rate_converter_pkg::deemph_t deemphasis_active,
  output logic [7:0] left_att_applied,
  output logic [7:0] right_att_applied
);
  import rate_converter_pkg::*;

  ctl_reg_if ctl1 ();
  ctl_reg_if ctl2 ();

  logic hit1;
  logic hit2;
  logic mute;
  logic track;
  logic auto_dem;
  deemph_t manual_deemphasis_select;
  deemph_t auto_sel;
  deemph_t next_dem;
  logic [7:0] next_ratt;

  assign hit1 = (host_addr == ctl1_addr);
  assign hit2 = (host_addr == ctl2_addr);
  assign host_hit = (host_wr | host_rd) & (hit1 | hit2);

  assign ctl1.wr = host_wr & hit1;
  assign ctl1.wdata = host_wdata;
  assign ctl2.wr = host_wr & hit2;
  assign ctl2.wdata = host_wdata;

  ctl_reg8 #(.mask(ctl1_mask), .reset_value(ctl_reset)) u_ctl1 (
    .core_clk(core_clk),
    .nrst(nrst),
    .port(ctl1)
  );
  ctl_reg8 #(.mask(ctl2_mask), .reset_value(ctl_reset)) u_ctl2 (
    .core_clk(core_clk),
    .nrst(nrst),
    .port(ctl2)
  );

  // registered read data
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= hit1 ? ctl1.q : (hit2 ? ctl2.q : 8'h00);
    end
  end

  assign converter_input_select = input_source_t'(ctl1.q[src_lsb +: 2]);
  assign converter_refclk_select = refclk_source_t'(ctl1.q[clk_lsb +: 2]);
  assign mute = ctl1.q[mute_bit];
  assign track = ctl1.q[track_bit];
  assign downsample_mode = ctl2.q[ddn_bit];
  assign manual_deemphasis_select = deemph_t'(ctl2.q[dem_lsb +: 2]);
  assign auto_dem = ctl2.q[auto_bit];

  function automatic logic [6:0] depth_of(input logic [1:0] code);
    case (code)
      2'h0: depth_of = depth_64;
      2'h1: depth_of = depth_32;
      2'h2: depth_of = depth_16;
      default: depth_of = depth_8;
    endcase
  endfunction : depth_of

  assign prebuffer_depth = depth_of(ctl2.q[depth_lsb +: 2]);

  always_comb begin
    auto_sel = dem_off;
    if (rx_cs_emphasis == cs_emph_5015) begin
      case (rx_cs_rate)
        cs_fs_48k: auto_sel = dem_48k;
        cs_fs_44k1: auto_sel = dem_44k1;
        cs_fs_32k: auto_sel = dem_32k;
        default: auto_sel = dem_off;
      endcase
    end
  end

  assign next_dem = auto_dem ? auto_sel : manual_deemphasis_select;

  assign next_ratt = track ? left_attenuation_value : right_attenuation_value;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      deemphasis_active <= dem_off;
      left_att_applied <= 8'h00;
      right_att_applied <= 8'h00;
    end else begin
      deemphasis_active <= next_dem;
      left_att_applied <= left_attenuation_value;
      right_att_applied <= next_ratt;
    end
  end

  // half-decibel steps: 2^(-n/12) per 0.5 dB is approximated by
  // a 6 dB shift per 12 counts plus a linear fraction within the octave
  function automatic logic [sample_width-1:0] attenuate(
    input logic [sample_width-1:0] s, input logic [7:0] n);
    logic signed [sample_width+7:0] wide;
    logic [3:0] frac;
    logic [4:0] sh;
    logic [7:0] gain;
    wide = '0;
    sh = 5'(n / 8'd12);
    frac = 4'(n % 8'd12);
    gain = 8'(8'd128 - (8'(frac) * 8'd5));
    wide = ($signed({{8{s[sample_width-1]}}, s}) * $signed({1'b0, gain})) >>> 7;
    wide = wide >>> sh;
    attenuate = wide[sample_width-1:0];
  endfunction : attenuate

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_left <= '0;
      out_right <= '0;
    end else if (mute) begin
      out_left <= '0;
      out_right <= '0;
    end else begin
      out_left <= attenuate(in_left, left_att_applied);
      out_right <= attenuate(in_right, right_att_applied);
    end
  end

  chk_mute_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    mute |=> (out_left == '0 && out_right == '0))
    else $error("mute did not zero output");
  chk_track_copy: assert property (@(posedge core_clk) disable iff (!nrst)
    track |=> (right_att_applied == $past(left_attenuation_value)))
    else $error("tracking not applied");
  chk_track_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !track |=> (right_att_applied == $past(right_attenuation_value)))
    else $error("right attenuation not independent");
  chk_auto_ignores: assert property (@(posedge core_clk) disable iff (!nrst)
    (auto_dem && rx_cs_emphasis != cs_emph_5015) |=> deemphasis_active == dem_off)
    else $error("manual field not ignored");
  chk_manual_dem: assert property (@(posedge core_clk) disable iff (!nrst)
    !auto_dem |=> deemphasis_active == $past(manual_deemphasis_select))
    else $error("manual de-emphasis wrong");
  chk_auto_rate: assert property (@(posedge core_clk) disable iff (!nrst)
    (auto_dem && rx_cs_emphasis == cs_emph_5015 && rx_cs_rate == cs_fs_32k)
      |=> deemphasis_active == dem_32k)
    else $error("auto de-emphasis rate wrong");
  chk_reset_zero: assert property (@(posedge core_clk)
    !nrst |=> (ctl1.q == 8'h00 && ctl2.q == 8'h00))
    else $error("control not zero after reset");
  chk_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    ctl1.wr |=> (ctl1.q & ~ctl1_mask) == 8'h00 ##0 ctl1.q == $past(host_wdata & ctl1_mask))
    else $error("reserved bits not zero");
  chk_depth_8: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctl2.wr && host_wdata[depth_lsb +: 2] == 2'h3) |=> prebuffer_depth == depth_8)
    else $error("depth code 3 not 8 samples");
  chk_source_write: assert property (@(posedge core_clk) disable iff (!nrst)
    ctl1.wr |=> converter_input_select == input_source_t'($past(host_wdata[1:0])))
    else $error("input source not updated");
  chk_ddn_write: assert property (@(posedge core_clk) disable iff (!nrst)
    ctl2.wr |=> downsample_mode == $past(host_wdata[ddn_bit]))
    else $error("down-sampling mode not updated");

  cov_mute: cover property (@(posedge core_clk) disable iff (!nrst) mute ##1 !mute);
  cov_track: cover property (@(posedge core_clk) disable iff (!nrst) track);
  cov_auto_48: cover property (@(posedge core_clk) disable iff (!nrst)
    deemphasis_active == dem_48k && auto_dem);
  cov_readback: cover property (@(posedge core_clk) disable iff (!nrst) host_rd && hit2);
endmodule : rate_converter_control_regs
`default_nettype wire

// >>> verification/test_rate_converter_control_regs.sv
// test_rate_converter_control_regs: directed bench for the two converter control registers.
// assumes: the design package and the register module are compiled ahead of this file.
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module test_rate_converter_control_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import rate_converter_pkg::*;
  logic core_clk;
  logic nrst = 1'b0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [6:0] host_addr = 7'h00;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata;
  logic host_hit;
  logic [7:0] left_attenuation_value = 8'h10;
  logic [7:0] right_attenuation_value = 8'h20;
  logic [2:0] rx_cs_emphasis = 3'h0;
  logic [3:0] rx_cs_rate = 4'h0;
  logic [23:0] in_left = 24'h123456;
  logic [23:0] in_right = 24'h654321;
  logic [23:0] out_left;
  logic [23:0] out_right;
  input_source_t converter_input_select;
  refclk_source_t converter_refclk_select;
  logic [6:0] prebuffer_depth;
  logic downsample_mode;
  deemph_t deemphasis_active;
  logic [7:0] left_att_applied;
  logic [7:0] right_att_applied;
  int errors = 0;
  int n_checks = 0;
  logic [6:0] depth_tab [4] = '{depth_64, depth_32, depth_16, depth_8};
  logic [3:0] rate_tab [4] = '{cs_fs_44k1, cs_fs_48k, cs_fs_32k, 4'h1};
  logic [1:0] auto_tab [4] = '{dem_44k1, dem_48k, dem_32k, dem_off};

  rate_converter_control_regs #(.sample_width(24)) DUT (
    .core_clk(core_clk), .nrst(nrst), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_hit(host_hit), .left_attenuation_value(left_attenuation_value),
    .right_attenuation_value(right_attenuation_value), .rx_cs_emphasis(rx_cs_emphasis),
    .rx_cs_rate(rx_cs_rate), .in_left(in_left), .in_right(in_right), .out_left(out_left),
    .out_right(out_right), .converter_input_select(converter_input_select),
    .converter_refclk_select(converter_refclk_select), .prebuffer_depth(prebuffer_depth),
    .downsample_mode(downsample_mode), .deemphasis_active(deemphasis_active),
    .left_att_applied(left_att_applied), .right_att_applied(right_att_applied)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    #1;
    `CHK("hit", (a == ctl1_addr || a == ctl2_addr), host_hit)
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string nm);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(nm, exp, host_rdata)
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd(ctl1_addr, 8'h00, "ctl1 reset");
    rd(ctl2_addr, 8'h00, "ctl2 reset");
    `CHK("depth reset", depth_64, prebuffer_depth)
    `CHK("source reset", 2'h0, converter_input_select)
    for (int i = 0; i < 4; i++) begin
      wr(ctl1_addr, 8'(i << src_lsb) | 8'(i << clk_lsb));
      settle(1);
      `CHK("source", 2'(i), converter_input_select)
      `CHK("refclk", 2'(i), converter_refclk_select)
      rd(ctl1_addr, 8'(i << src_lsb) | 8'(i << clk_lsb), "ctl1 readback");
    end
    for (int i = 0; i < 4; i++) begin
      wr(ctl2_addr, 8'(i) | 8'((i % 2) << ddn_bit));
      settle(1);
      `CHK("depth", depth_tab[i], prebuffer_depth)
      `CHK("downsample", 1'(i % 2), downsample_mode)
    end
    // unused bits and unmapped place
    wr(ctl1_addr, 8'hFF);
    rd(ctl1_addr, ctl1_mask, "ctl1 unused");
    wr(ctl2_addr, 8'hFF);
    wr(7'h2F, 8'hA5);
    rd(ctl2_addr, ctl2_mask, "ctl2 unused");
    rd(7'h2F, 8'h00, "unmapped");
    // attenuation and mute
    left_attenuation_value <= 8'h00;
    right_attenuation_value <= 8'h00;
    wr(ctl1_addr, 8'h00);
    settle(3);
    `CHK("unity left", in_left, out_left)
    wr(ctl1_addr, 8'(1 << mute_bit));
    settle(3);
    `CHK("mute left", 24'h000000, out_left)
    `CHK("mute right", 24'h000000, out_right)
    wr(ctl1_addr, 8'h00);
    settle(3);
    `CHK("unmute right", in_right, out_right)
    left_attenuation_value <= 8'h10;
    right_attenuation_value <= 8'h20;
    settle(2);
    `CHK("att left", 8'h10, left_att_applied)
    `CHK("att right", 8'h20, right_att_applied)
    wr(ctl1_addr, 8'(1 << track_bit));
    settle(3);
    `CHK("track right", 8'h10, right_att_applied)
    `CHK("track left", 8'h10, left_att_applied)
    left_attenuation_value <= 8'h0C;
    settle(3);
    `CHK("six db left", 24'h091A2B, out_left)
    for (int i = 0; i < 4; i++) begin
      wr(ctl2_addr, 8'(i << dem_lsb));
      settle(3);
      `CHK("manual dem", 2'(i), deemphasis_active)
    end
    // automatic mode with manual field parked at 32k
    rx_cs_emphasis <= cs_emph_5015;
    wr(ctl2_addr, 8'(1 << auto_bit) | 8'(3 << dem_lsb));
    for (int i = 0; i < 4; i++) begin
      rx_cs_rate <= rate_tab[i];
      settle(3);
      `CHK("auto dem", auto_tab[i], deemphasis_active)
    end
    rx_cs_rate <= cs_fs_48k;
    rx_cs_emphasis <= 3'h0;
    settle(3);
    `CHK("auto no emph", 2'(dem_off), deemphasis_active)
    rx_cs_emphasis <= cs_emph_5015;
    settle(3);
    `CHK("auto ignores manual", 2'(dem_48k), deemphasis_active)
    // second reset mid-run
    nrst <= 1'b0;
    settle(2);
    nrst <= 1'b1;
    rd(ctl2_addr, 8'h00, "ctl2 rereset");
    rd(ctl1_addr, 8'h00, "ctl1 rereset");
    tally_and_finish();
  end
endmodule : test_rate_converter_control_regs
`undef CHK
`default_nettype wire
